/* File: inc/sipc_pkg.sv */
// sipc_pkg: offsets, fields, reset values and codes of the slot control block
// assumes an APB slave with 32-bit data and byte lanes on pstrb
// Operation
// R1 - The power indicator field is two read-write bits that reset to 11b, meaning off.
// R2 - Power indicator codes are 01b on, 10b blink, 11b off, and 00b is reserved.
// R3 - A write to the power indicator field sends the matching power indicator message downstream; a write of reserved code 00b sends none here.
// R4 - A write to the attention indicator field sends the matching attention indicator message.
// R5 - The power control bit is read-write; 0b asks for slot power on and 1b for power off.
// R6 - When the link-state-change enable is 1b, a change of link-active is notified to software.
// R7 - Bit 11 is reserved, reads as zero and ignores writes.
package sipc_pkg;
  localparam int unsigned  SIPC_AW        = 12;
  localparam logic [11:0]  SIPC_CTRL_OFS  = 12'h000;
  localparam logic [11:0]  SIPC_STAT_OFS  = 12'h004;
  localparam int unsigned  SIPC_ATT_LSB   = 6;
  localparam int unsigned  SIPC_PWR_LSB   = 8;
  localparam int unsigned  SIPC_PCTL_BIT  = 10;
  localparam int unsigned  SIPC_RSVD_BIT  = 11;
  localparam int unsigned  SIPC_LSCE_BIT  = 12;
  localparam int unsigned  SIPC_ST_LACT   = 0;
  localparam int unsigned  SIPC_ST_LCHG   = 1;
  localparam int unsigned  SIPC_ST_BUSY   = 2;
  localparam logic [1:0]   SIPC_IND_RSVD  = 2'h0;
  localparam logic [1:0]   SIPC_IND_ON    = 2'h1;
  localparam logic [1:0]   SIPC_IND_BLINK = 2'h2;
  localparam logic [1:0]   SIPC_IND_OFF   = 2'h3;
  localparam logic [1:0]   SIPC_ATT_RST   = 2'h3;
  localparam logic [1:0]   SIPC_PWR_RST   = 2'h3;
  localparam logic         SIPC_PCTL_RST  = 1'b0;
  localparam logic         SIPC_LSCE_RST  = 1'b0;

  typedef enum logic
  {
    SIPC_MSG_ATT,
    SIPC_MSG_PWR
  } sipc_msg_kind_t;
endpackage : sipc_pkg

/* File: inc/sipc_msg_if.sv */
// sipc_msg_if: message requests from the register bank to the message emitter
// assumes both ends on clk_i
`timescale 1ns/100ps
interface sipc_msg_if;
  logic       att_req;
  logic       pwr_req;
  logic [1:0] att_code;
  logic [1:0] pwr_code;
  logic       busy;

  modport bank
  (
    output att_req,
    output pwr_req,
    output att_code,
    output pwr_code,
    input  busy
  );

  modport emit
  (
    input  att_req,
    input  pwr_req,
    input  att_code,
    input  pwr_code,
    output busy
  );
endinterface : sipc_msg_if

/* File: hdl/sipc_msg_emit.sv */
// sipc_msg_emit: queues one attention and one power indicator message
// assumes the downstream side takes a message on msg_valid_o and msg_ready_i
`timescale 1ns/100ps
module sipc_msg_emit
  import sipc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  sipc_msg_if.emit             req,
  output sipc_pkg::sipc_msg_kind_t msg_kind_o,
  output logic [1:0]           msg_code_o,
  output logic                 msg_valid_o,
  input  wire logic            msg_ready_i
);
  logic       att_pend_r;
  logic       pwr_pend_r;
  logic [1:0] att_code_r;
  logic [1:0] pwr_code_r;
  logic       load;
  logic       grant_att;
  logic       grant_pwr;

  assign load      = !msg_valid_o || msg_ready_i;
  assign grant_att = load && att_pend_r;
  assign grant_pwr = load && !att_pend_r && pwr_pend_r;
  assign req.busy  = att_pend_r || pwr_pend_r || msg_valid_o;

  // pending attention message, latest setting wins
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      att_pend_r <= 1'b0;
      att_code_r <= SIPC_ATT_RST;
    end
    else if (req.att_req)
    begin
      att_pend_r <= 1'b1; // R4
      att_code_r <= req.att_code;
    end
    else if (grant_att)
      att_pend_r <= 1'b0;
  end

  // pending power indicator message
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pwr_pend_r <= 1'b0;
      pwr_code_r <= SIPC_PWR_RST;
    end
    else if (req.pwr_req)
    begin
      pwr_pend_r <= 1'b1; // R3
      pwr_code_r <= req.pwr_code;
    end
    else if (grant_pwr)
      pwr_pend_r <= 1'b0;
  end

  // output message register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      msg_valid_o <= 1'b0;
      msg_kind_o  <= SIPC_MSG_ATT;
      msg_code_o  <= SIPC_IND_OFF;
    end
    else if (grant_att)
    begin
      msg_valid_o <= 1'b1;
      msg_kind_o  <= SIPC_MSG_ATT;
      msg_code_o  <= att_code_r;
    end
    else if (grant_pwr)
    begin
      msg_valid_o <= 1'b1;
      msg_kind_o  <= SIPC_MSG_PWR;
      msg_code_o  <= pwr_code_r;
    end
    else if (msg_ready_i)
      msg_valid_o <= 1'b0;
  end

  chk_msg_hold: assert property (@(posedge clk_i) disable iff (srst_i) // R3
    msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_code_o) && $stable(msg_kind_o))
    else $error("message dropped before it was taken");

  chk_pwr_code_legal: assert property (@(posedge clk_i) disable iff (srst_i) // R2
    msg_valid_o && msg_kind_o == SIPC_MSG_PWR |-> msg_code_o != SIPC_IND_RSVD)
    else $error("reserved power indicator code sent");
endmodule : sipc_msg_emit

/* File: hdl/sipc_slot_ctrl.sv */
// sipc_slot_ctrl: slot control and status registers of one downstream port
// assumes an APB master on clk_i and a downstream message sink with ready
`timescale 1ns/100ps
module sipc_slot_ctrl
  import sipc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [sipc_pkg::SIPC_AW-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  output logic                         pready_o,
  output logic [31:0]                  prdata_o,
  output logic                         pslverr_o,
  input  wire logic                    link_active_i,
  output logic [1:0]                   att_ind_o,
  output logic [1:0]                   pwr_ind_o,
  output logic                         slot_power_off_o,
  output logic                         link_notify_o,
  output sipc_pkg::sipc_msg_kind_t     msg_kind_o,
  output logic [1:0]                   msg_code_o,
  output logic                         msg_valid_o,
  input  wire logic                    msg_ready_i
);
  logic        lsce_r;
  logic        lact_r;
  logic        lchg_r;
  logic        setup;
  logic        wr_acc;
  logic        ctrl_wr;
  logic        stat_wr;
  logic [31:0] rd_nxt;
  logic        err_nxt;

  sipc_msg_if msg_if ();

  function automatic logic [31:0] ctrl_word(input logic [1:0] att, input logic [1:0] pwr,
                                            input logic pctl, input logic lsce);
    logic [31:0] w;
    w = 32'h0;
    w[SIPC_ATT_LSB +: 2] = att;
    w[SIPC_PWR_LSB +: 2] = pwr;
    w[SIPC_PCTL_BIT]     = pctl;
    w[SIPC_RSVD_BIT]     = 1'b0; // R7
    w[SIPC_LSCE_BIT]     = lsce;
    return w;
  endfunction : ctrl_word

  assign setup    = psel_i && !penable_i;
  assign pready_o = psel_i && penable_i;
  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign ctrl_wr  = wr_acc && paddr_i == SIPC_CTRL_OFS;
  assign stat_wr  = wr_acc && paddr_i == SIPC_STAT_OFS;

  // read data and error prepared in the setup cycle
  always_comb
  begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    if (paddr_i == SIPC_CTRL_OFS)
      rd_nxt = ctrl_word(att_ind_o, pwr_ind_o, slot_power_off_o, lsce_r);
    else if (paddr_i == SIPC_STAT_OFS)
    begin
      rd_nxt[SIPC_ST_LACT] = lact_r;
      rd_nxt[SIPC_ST_LCHG] = lchg_r;
      rd_nxt[SIPC_ST_BUSY] = msg_if.busy;
    end
    else
      err_nxt = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o  <= pwrite_i ? 32'h0 : rd_nxt;
      pslverr_o <= err_nxt;
    end
  end

  // indicator fields, byte lane 0 and 1
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      att_ind_o <= SIPC_ATT_RST;
      pwr_ind_o <= SIPC_PWR_RST; // R1
    end
    else if (ctrl_wr)
    begin
      if (pstrb_i[0])
        att_ind_o <= pwdata_i[SIPC_ATT_LSB +: 2];
      if (pstrb_i[1])
        pwr_ind_o <= pwdata_i[SIPC_PWR_LSB +: 2]; // R1
    end
  end

  // power control and link-state enable; bit 11 has no storage
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      slot_power_off_o <= SIPC_PCTL_RST;
      lsce_r           <= SIPC_LSCE_RST;
    end
    else if (ctrl_wr && pstrb_i[1])
    begin
      slot_power_off_o <= pwdata_i[SIPC_PCTL_BIT]; // R5
      lsce_r           <= pwdata_i[SIPC_LSCE_BIT];
    end
  end

  // message requests; reserved power code sends nothing
  assign msg_if.att_req  = ctrl_wr && pstrb_i[0]; // R4
  assign msg_if.att_code = pwdata_i[SIPC_ATT_LSB +: 2];
  assign msg_if.pwr_req  = ctrl_wr && pstrb_i[1]
                           && pwdata_i[SIPC_PWR_LSB +: 2] != SIPC_IND_RSVD; // R2 R3
  assign msg_if.pwr_code = pwdata_i[SIPC_PWR_LSB +: 2];

  // link-active change, sticky, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      lact_r <= 1'b0;
      lchg_r <= 1'b0;
    end
    else
    begin
      lact_r <= link_active_i;
      if (lact_r != link_active_i)
        lchg_r <= 1'b1;
      else if (stat_wr && pstrb_i[0] && pwdata_i[SIPC_ST_LCHG])
        lchg_r <= 1'b0;
    end
  end

  assign link_notify_o = lsce_r && lchg_r; // R6

  sipc_msg_emit u_emit
  (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .req         (msg_if.emit),
    .msg_kind_o  (msg_kind_o),
    .msg_code_o  (msg_code_o),
    .msg_valid_o (msg_valid_o),
    .msg_ready_i (msg_ready_i)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_pwr_reset_off: assert property ($fell(srst_i) |-> pwr_ind_o == SIPC_IND_OFF) // R1
    else $error("power indicator not off after reset");

  chk_pwr_write_msg: assert property (ctrl_wr && pstrb_i[1] && !msg_valid_o // R3
    && pwdata_i[SIPC_PWR_LSB +: 2] != SIPC_IND_RSVD && !pstrb_i[0]
    |=> ##1 msg_valid_o && msg_kind_o == SIPC_MSG_PWR && msg_code_o == pwr_ind_o)
    else $error("power indicator write sent no message");

  chk_att_write_msg: assert property (ctrl_wr && pstrb_i[0] && !msg_valid_o // R4
    |=> ##1 msg_valid_o && msg_kind_o == SIPC_MSG_ATT && msg_code_o == att_ind_o)
    else $error("attention indicator write sent no message");

  chk_pctl_follows: assert property (ctrl_wr && pstrb_i[1] // R5
    |=> slot_power_off_o == $past(pwdata_i[SIPC_PCTL_BIT]))
    else $error("power control bit not taken");

  chk_link_notify: assert property (lsce_r && lact_r != link_active_i // R6
    && !(ctrl_wr && pstrb_i[1]) |=> link_notify_o)
    else $error("link change not notified");

  chk_rsvd_zero: assert property (setup && !pwrite_i && paddr_i == SIPC_CTRL_OFS // R7
    |=> prdata_o[SIPC_RSVD_BIT] == 1'b0)
    else $error("reserved bit read nonzero");

  chk_ind_reset: assert property ($fell(srst_i) |-> att_ind_o == SIPC_IND_OFF // R1
    && !slot_power_off_o && !link_notify_o)
    else $error("control fields wrong after reset");

  chk_pwr_write_take: assert property (ctrl_wr && pstrb_i[1] // R1
    |=> pwr_ind_o == $past(pwdata_i[SIPC_PWR_LSB +: 2]))
    else $error("power indicator write not stored");

  chk_lane_off_keep: assert property (ctrl_wr && !pstrb_i[1] // R1
    |=> $stable(pwr_ind_o) && $stable(slot_power_off_o) && $stable(lsce_r))
    else $error("fields of a disabled byte lane changed");

  chk_rsvd_no_msg: assert property (ctrl_wr && pstrb_i[1] && !pstrb_i[0] && !msg_if.busy // R2
    && pwdata_i[SIPC_PWR_LSB +: 2] == SIPC_IND_RSVD |=> ##1 !msg_valid_o)
    else $error("message sent for reserved power code");

  chk_lchg_sets: assert property (lact_r != link_active_i |=> lchg_r) // R6
    else $error("link change flag not set");

  chk_lchg_clears: assert property (stat_wr && pstrb_i[0] && pwdata_i[SIPC_ST_LCHG] // R6
    && lact_r == link_active_i |=> !lchg_r)
    else $error("link change flag not cleared");

  chk_lsce_follows: assert property (ctrl_wr && pstrb_i[1] // R6
    |=> lsce_r == $past(pwdata_i[SIPC_LSCE_BIT]))
    else $error("link change enable not taken");

  chk_stat_read: assert property (setup && !pwrite_i && paddr_i == SIPC_STAT_OFS // R6
    |=> prdata_o[SIPC_ST_LCHG] == $past(lchg_r) && prdata_o[SIPC_ST_LACT] == $past(lact_r))
    else $error("status read does not match the flags");

  cov_pwr_blink: cover property (msg_valid_o && msg_ready_i && msg_code_o == SIPC_IND_BLINK);
  cov_two_msgs:  cover property (ctrl_wr && pstrb_i[0] && pstrb_i[1]);
  cov_notify:    cover property ($rose(link_notify_o));
  cov_bad_addr:  cover property (pready_o && pslverr_o);
  cov_rsvd_pwr:  cover property (ctrl_wr && pstrb_i[1]
                                 && pwdata_i[SIPC_PWR_LSB +: 2] == SIPC_IND_RSVD);
endmodule : sipc_slot_ctrl

/* File: bench/sipc_sink_model.sv */
// sipc_sink_model: downstream message sink, logs every taken message
// assumes valid and kind/code held until taken; stall_i drops ready
`timescale 1ns/100ps
module sipc_sink_model
  import sipc_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               stall_i,
  input  sipc_pkg::sipc_msg_kind_t kind_i,
  input  wire logic [1:0]         code_i,
  input  wire logic               valid_i,
  output logic                    ready_o,
  output logic [7:0]              cnt_o,
  output logic [2:0]              log_o [8]
);
  assign ready_o = !stall_i;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cnt_o <= 8'h00;
    else if (valid_i && ready_o)
    begin
      log_o[cnt_o[2:0]] <= {kind_i, code_i};
      cnt_o             <= cnt_o + 8'h01;
    end
  end
endmodule : sipc_sink_model

/* File: bench/sipc_slot_ctrl_tb.sv */
// sipc_slot_ctrl_tb: apb register and message tests of the slot control block
// assumes zero-wait apb slave and the sink model on the message port
`timescale 1ns/100ps
module sipc_slot_ctrl_tb;
  import sipc_pkg::*;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, link = 0, stall = 0;
  logic [11:0] addr = '0;
  logic [31:0] wd = '0, rd;
  logic [3:0] strb = '0;
  logic rdy, err, poff, ntf, mv, mr;
  logic [31:0] prd;
  logic [1:0] att, pind, mc;
  sipc_msg_kind_t mk;
  logic [7:0] cnt;
  logic [2:0] lg [8];
  int n_mismatch = 0, check_count = 0, idx = 0, k;
  logic [1:0] codes [3] = '{SIPC_IND_ON, SIPC_IND_BLINK, SIPC_IND_OFF};
  always #4 clk = ~clk;
  sipc_slot_ctrl uut (.clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .pstrb_i(strb), .pready_o(rdy),
    .prdata_o(prd), .pslverr_o(err), .link_active_i(link), .att_ind_o(att),
    .pwr_ind_o(pind), .slot_power_off_o(poff), .link_notify_o(ntf),
    .msg_kind_o(mk), .msg_code_o(mc), .msg_valid_o(mv), .msg_ready_i(mr));
  sipc_sink_model snk (.clk_i(clk), .srst_i(srst), .stall_i(stall), .kind_i(mk),
    .code_i(mc), .valid_i(mv), .ready_o(mr), .cnt_o(cnt), .log_o(lg));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; addr <= a; wd <= d; strb <= s;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask : apb
  task automatic msg(input logic [2:0] exp);
    for (k = 0; k < 30 && cnt <= idx; k++)
      @(posedge clk);
    chk("message", lg[idx[2:0]], exp);
    idx++;
  endtask : msg
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 0;
    apb(0, SIPC_CTRL_OFS, 0, 0);
    chk("ctrl reset", rd, 32'h0000_03c0);
    chk("pwr reset", pind, SIPC_PWR_RST);
    chk("poff reset", poff, 0);
    chk("ctrl err", err, 0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, SIPC_CTRL_OFS, {22'h0, codes[i], 8'h00}, 4'h2);
      chk("pwr ind", pind, codes[i]);
      msg({1'b1, codes[i]});
    end
    stall <= 1;
    apb(1, SIPC_CTRL_OFS, 32'h0000_0e40, 4'h3);
    repeat (4) @(posedge clk);
    apb(0, SIPC_STAT_OFS, 0, 0);
    chk("stat busy", rd, 32'h0000_0004);
    chk("stalled", cnt, 8'h03);
    stall <= 0;
    msg(3'b001);
    msg(3'b110);
    chk("poff", poff, 1);
    apb(0, SIPC_CTRL_OFS, 0, 0);
    chk("ctrl bit11", rd, 32'h0000_0640);
    apb(1, SIPC_CTRL_OFS, 32'h0000_1200, 4'h2);
    msg(3'b110);
    chk("poff", poff, 0);
    chk("att kept", att, 2'h1);
    apb(1, SIPC_CTRL_OFS, 32'h0000_0080, 4'h1);
    msg(3'b010);
    chk("att blink", att, SIPC_IND_BLINK);
    chk("pwr kept", pind, SIPC_IND_BLINK);
    apb(1, SIPC_STAT_OFS, 32'h2, 4'h1);
    chk("notify idle", ntf, 0);
    link <= 1;
    for (k = 0; k < 10 && ntf !== 1'b1; k++)
      @(posedge clk);
    chk("notify", ntf, 1);
    apb(0, SIPC_STAT_OFS, 0, 0);
    chk("stat link", rd, 32'h0000_0003);
    apb(1, SIPC_STAT_OFS, 32'h2, 4'h1);
    chk("notify clr", ntf, 0);
    apb(1, SIPC_CTRL_OFS, 32'h0000_0300, 4'h2);
    msg(3'b111);
    link <= 0;
    repeat (5) @(posedge clk);
    chk("notify off", ntf, 0);
    apb(1, SIPC_CTRL_OFS, 32'h0000_0000, 4'h2);
    repeat (4) @(posedge clk);
    chk("pwr rsvd", pind, SIPC_IND_RSVD);
    chk("rsvd no msg", cnt, 8'h08);
    apb(0, 12'h008, 0, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    close_out();
  end
endmodule : sipc_slot_ctrl_tb
